/* inc/rbc_params.svh */
// Register map, field positions and codes of the receive bit handling block
`ifndef RBC_PARAMS_SVH
`define RBC_PARAMS_SVH

// Register indices; byte address is four times the index
`define RBC_IDX_ERROR      6'h0a
`define RBC_IDX_STATUS     6'h0b
`define RBC_IDX_BITCTL     6'h0c
`define RBC_IDX_CONFLICT   6'h0d
`define RBC_IDX_IRQ_STAT   6'h20
`define RBC_IDX_IRQ_MASK   6'h21

// link_status fields
`define RBC_STAT_CIPHER    5
// rx_error fields
`define RBC_ERR_CONFLICT   2
`define RBC_ERR_INTEGRITY  0
// rx_bit_control fields
`define RBC_CTL_KEEP       7
`define RBC_CTL_INTEG      3
`define RBC_BITCTL_RESET   8'h00
// rx_collision_position fields
`define RBC_CONF_VALID     7
`define RBC_CONF_MAX       7'h3f
`define RBC_CONF_SAT       7'h40

// Interrupt status and mask bits
`define RBC_IRQ_CONFLICT   0
`define RBC_IRQ_INTEGRITY  1
`define RBC_IRQ_FRAME      2
`define RBC_IRQ_WIDTH      3

// transceive_state codes
`define RBC_CODE_IDLE      3'h0
`define RBC_CODE_TX_WAIT   3'h1
`define RBC_CODE_TX        3'h3
`define RBC_CODE_RX_WAIT   3'h5
`define RBC_CODE_DATA_WAIT 3'h6
`define RBC_CODE_RX        3'h7

`endif

/* inc/rbc_pkg.sv */
// Types shared by the receive bit handling block
package rbc_pkg;

    typedef enum logic [2:0] {
        RBC_IDLE,
        RBC_TX_WAIT,
        RBC_TX,
        RBC_RX_WAIT,
        RBC_DATA_WAIT,
        RBC_RX
    } rbc_state_t;

    // One decoded bit from the receive decoder
    typedef struct packed {
        logic valid;
        logic value;
        logic conflict;
    } rbc_rx_bit_t;

    // One assembled byte towards the data path
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } rbc_byte_t;

endpackage

/* logic/rbc_bit_packer.sv */
// Packs decoded bits into bytes starting at a chosen bit slot
`timescale 1ns/1ns
`include "rbc_params.svh"
module rbc_bit_packer (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Frame control
    input  wire logic             start,
    input  wire logic [2:0]       slot,
    input  wire logic             frame_end,
    // Bit stream
    input  wire logic             bit_valid,
    input  wire logic             bit_value,
    // Byte stream
    output rbc_pkg::rbc_byte_t    byte_out,
    output logic                  bit_oriented,
    output logic                  last_load,
    output logic [2:0]            last_bits
);
    import rbc_pkg::*;

    logic [2:0] fill;
    logic [7:0] shift;
    logic [7:0] next_shift;

    always_comb begin
        next_shift       = shift;
        next_shift[fill] = bit_value;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fill  <= 3'h0;
            shift <= 8'h00;
        end else if (start) begin
            fill  <= slot;
            shift <= 8'h00;
        end else if (bit_valid) begin
            fill  <= fill + 3'h1;
            shift <= (fill == 3'h7) ? 8'h00 : next_shift;
        end else if (frame_end) begin
            shift <= 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bit_oriented <= 1'b0;
        end else if (start) begin
            bit_oriented <= (slot != 3'h0);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            byte_out <= '0;
        end else if (bit_valid && fill == 3'h7) begin
            byte_out <= '{valid: 1'b1, data: next_shift, last: 1'b0};
        end else if (frame_end && fill != 3'h0) begin
            byte_out <= '{valid: 1'b1, data: shift, last: 1'b1};
        end else begin
            byte_out <= '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            last_load <= 1'b0;
            last_bits <= 3'h0;
        end else begin
            last_load <= frame_end && bit_oriented;
            last_bits <= fill;
        end
    end
endmodule

/* logic/rbc_conflict_tracker.sv */
// First collision position tracking for one received frame
`timescale 1ns/1ns
`include "rbc_params.svh"
module rbc_conflict_tracker (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Frame control
    input  wire logic             start,
    input  wire logic [2:0]       slot,
    // Decoded bit
    input  wire rbc_pkg::rbc_rx_bit_t bit_in,
    // Results
    output logic                  after_conflict,
    output logic                  pos_valid,
    output logic [6:0]            pos
);
    import rbc_pkg::*;

    logic [6:0] bit_index;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bit_index <= 7'h00;
        end else if (start) begin
            bit_index <= {4'h0, slot};
        end else if (bit_in.valid && bit_index != `RBC_CONF_SAT) begin
            bit_index <= bit_index + 7'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || start) begin
            after_conflict <= 1'b0;
            pos_valid      <= 1'b0;
            pos            <= 7'h00;
        end else if (bit_in.valid && bit_in.conflict && !after_conflict) begin
            after_conflict <= 1'b1;
            pos_valid      <= (bit_index <= `RBC_CONF_MAX);
            pos            <= (bit_index <= `RBC_CONF_MAX) ? bit_index : 7'h00;
        end
    end
endmodule

/* logic/rbc_top.sv */
// Receive bit handling, collision status and link status registers
`timescale 1ns/1ns
`include "rbc_params.svh"
module rbc_top (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    // Avalon-MM slave
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    // Framing engine events
    input  wire logic                  ev_tx_request,
    input  wire logic                  ev_tx_begin,
    input  wire logic                  ev_tx_end,
    input  wire logic                  ev_rx_request,
    input  wire logic                  ev_rx_guard_done,
    input  wire logic                  ev_rx_sof,
    input  wire logic                  ev_rx_end,
    input  wire logic                  ev_parity_err,
    input  wire logic                  ev_crc_err,
    input  wire logic                  ev_auth_done,
    // Decoded receive bits
    input  wire rbc_pkg::rbc_rx_bit_t  rx_in,
    // Assembled bytes
    output rbc_pkg::rbc_byte_t         byte_out,
    // Status towards the rest of the chip
    output logic                       cipher_active,
    output logic [2:0]                 transceive_state,
    output logic                       irq
);
    import rbc_pkg::*;

    rbc_state_t state;
    rbc_state_t next_state;

    logic       ack;
    logic [5:0] index;
    logic       wr_en;
    logic [7:0] wdata;

    logic       keep_bits_after_conflict;
    logic [2:0] first_bit_slot;
    logic       conflict_as_integrity_fault;
    logic [2:0] final_byte_bit_count;

    logic       conflict_seen;
    logic       integrity_fault;
    logic [`RBC_IRQ_WIDTH-1:0] irq_status;
    logic [`RBC_IRQ_WIDTH-1:0] irq_mask;
    logic [`RBC_IRQ_WIDTH-1:0] irq_event;

    logic        rx_phase_start;
    logic        rx_active;
    rbc_rx_bit_t rx_bit;
    logic        masked_value;
    logic        after_conflict;
    logic        conflict_slot_valid;
    logic [6:0]  conflict_slot;
    logic        last_load;
    logic [2:0]  last_bits;
    logic        conflict_hit;
    logic        frame_done;

    // Bus access: one wait cycle, then the answer
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign index           = avs_address[7:2];
    assign wr_en           = avs_write && ack && avs_byteenable[0];
    assign wdata           = avs_writedata[7:0];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    // Transceive sequence
    always_comb begin
        next_state = state;
        unique case (state)
            RBC_IDLE: begin
                if (ev_tx_request) begin
                    next_state = RBC_TX_WAIT;
                end else if (ev_rx_request) begin
                    next_state = RBC_DATA_WAIT;
                end
            end
            RBC_TX_WAIT: begin
                if (ev_tx_begin) begin
                    next_state = RBC_TX;
                end
            end
            RBC_TX: begin
                if (ev_tx_end) begin
                    next_state = RBC_RX_WAIT;
                end
            end
            RBC_RX_WAIT: begin
                if (ev_rx_guard_done) begin
                    next_state = RBC_DATA_WAIT;
                end
            end
            RBC_DATA_WAIT: begin
                if (ev_rx_sof) begin
                    next_state = RBC_RX;
                end
            end
            RBC_RX: begin
                if (ev_rx_end) begin
                    next_state = RBC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= RBC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            transceive_state <= `RBC_CODE_IDLE;
        end else begin
            unique case (next_state)
                RBC_IDLE:      transceive_state <= `RBC_CODE_IDLE;
                RBC_TX_WAIT:   transceive_state <= `RBC_CODE_TX_WAIT;
                RBC_TX:        transceive_state <= `RBC_CODE_TX;
                RBC_RX_WAIT:   transceive_state <= `RBC_CODE_RX_WAIT;
                RBC_DATA_WAIT: transceive_state <= `RBC_CODE_DATA_WAIT;
                RBC_RX:        transceive_state <= `RBC_CODE_RX;
            endcase
        end
    end

    // Receive phase starts on entry to the wait-for-data state
    assign rx_phase_start = (next_state == RBC_DATA_WAIT) && (state != RBC_DATA_WAIT);
    assign rx_active      = (state == RBC_RX);
    assign frame_done     = rx_active && ev_rx_end;

    // Bits outside the receiving state are not data and are dropped
    assign rx_bit = '{valid:    rx_in.valid && rx_active,
                      value:    rx_in.value,
                      conflict: rx_in.conflict};
    assign conflict_hit    = rx_bit.valid && rx_bit.conflict;

    assign masked_value = rx_bit.value && (keep_bits_after_conflict || !after_conflict);

    rbc_conflict_tracker u_tracker (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .start          (rx_phase_start),
        .slot           (first_bit_slot),
        .bit_in         (rx_bit),
        .after_conflict (after_conflict),
        .pos_valid      (conflict_slot_valid),
        .pos            (conflict_slot)
    );

    rbc_bit_packer u_packer (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .start        (rx_phase_start),
        .slot         (first_bit_slot),
        .frame_end    (frame_done),
        .bit_valid    (rx_bit.valid),
        .bit_value    (masked_value),
        .byte_out     (byte_out),
        .bit_oriented (),
        .last_load    (last_load),
        .last_bits    (last_bits)
    );

    // Control fields; slot changes mid-frame only affect the next frame
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            keep_bits_after_conflict    <= 1'(`RBC_BITCTL_RESET >> `RBC_CTL_KEEP);
            first_bit_slot              <= 3'h0;
            conflict_as_integrity_fault <= 1'b0;
        end else if (wr_en && index == `RBC_IDX_BITCTL) begin
            keep_bits_after_conflict    <= wdata[`RBC_CTL_KEEP];
            first_bit_slot              <= wdata[6:4];
            conflict_as_integrity_fault <= wdata[`RBC_CTL_INTEG];
        end
    end

    // Decoder update wins over a host write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            final_byte_bit_count <= 3'h0;
        end else if (last_load) begin
            final_byte_bit_count <= last_bits;
        end else if (rx_phase_start) begin
            final_byte_bit_count <= 3'h0;
        end else if (wr_en && index == `RBC_IDX_BITCTL) begin
            final_byte_bit_count <= wdata[2:0];
        end
    end

    // Cipher state: only authentication sets it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cipher_active <= 1'b0;
        end else if (ev_auth_done) begin
            cipher_active <= 1'b1;
        end else if (wr_en && index == `RBC_IDX_STATUS && !wdata[`RBC_STAT_CIPHER]) begin
            cipher_active <= 1'b0;
        end
    end

    // conflict flag, cleared at receive start
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            conflict_seen <= 1'b0;
        end else if (conflict_hit) begin
            conflict_seen <= 1'b1;
        end else if (rx_phase_start) begin
            conflict_seen <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            integrity_fault <= 1'b0;
        end else if ((rx_active && (ev_parity_err || ev_crc_err)) ||
                     (conflict_hit && conflict_as_integrity_fault)) begin
            integrity_fault <= 1'b1;
        end else if (rx_phase_start) begin
            integrity_fault <= 1'b0;
        end
    end

    // Interrupt events
    assign irq_event[`RBC_IRQ_CONFLICT]  = conflict_hit && !conflict_seen;
    assign irq_event[`RBC_IRQ_INTEGRITY] = (rx_active && (ev_parity_err || ev_crc_err)) ||
                                           (conflict_hit && conflict_as_integrity_fault);
    assign irq_event[`RBC_IRQ_FRAME]     = frame_done;

    // Sticky bits; a new event beats a write-one clear
    genvar g;
    generate
        for (g = 0; g < `RBC_IRQ_WIDTH; g = g + 1) begin : g_irq
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    irq_status[g] <= 1'b0;
                end else if (irq_event[g]) begin
                    irq_status[g] <= 1'b1;
                end else if (wr_en && index == `RBC_IDX_IRQ_STAT && wdata[g]) begin
                    irq_status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_mask <= '0;
        end else if (wr_en && index == `RBC_IDX_IRQ_MASK) begin
            irq_mask <= wdata[`RBC_IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read data captured on the wait cycle, stands on the answer cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack) begin
            unique case (index)
                `RBC_IDX_ERROR:
                    avs_readdata <= {29'h0, conflict_seen, 1'b0, integrity_fault};
                `RBC_IDX_STATUS:
                    avs_readdata <= {26'h0, cipher_active, 2'h0, transceive_state};
                `RBC_IDX_BITCTL:
                    avs_readdata <= {24'h0, keep_bits_after_conflict, first_bit_slot,
                                     conflict_as_integrity_fault, final_byte_bit_count};
                // Position reads zero whenever the valid bit is clear
                `RBC_IDX_CONFLICT:
                    avs_readdata <= {24'h0, conflict_slot_valid, conflict_slot};
                `RBC_IDX_IRQ_STAT:
                    avs_readdata <= {29'h0, irq_status};
                `RBC_IDX_IRQ_MASK:
                    avs_readdata <= {29'h0, irq_mask};
                default:
                    avs_readdata <= 32'h00000000;
            endcase
        end
    end
endmodule

/* test/rbc_card_model.sv */
// Behavioural card and framing engine, one frame per request
`timescale 1ns/1ns
module rbc_card_model (
    // Clock
    input logic                  ref_clk,
    // Frame request
    input logic                  go,
    input logic                  tx,
    input logic                  slow,
    input logic [6:0]            nbits,
    input logic [63:0]           bits,
    input logic [6:0]            conf_at,
    input logic [1:0]            err,
    // Towards the block
    output logic [6:0]           ev,
    output logic                 par,
    output logic                 crc,
    output rbc_pkg::rbc_rx_bit_t rx_in,
    output logic                 busy
);
    import rbc_pkg::*;
    task automatic step(input int i);
        ev <= 7'h1 << i;
        @(posedge ref_clk);
        ev <= 7'h0;
        repeat (slow ? 3 : 1) @(posedge ref_clk);
    endtask
    initial begin
        ev = 7'h0;
        {crc, par, busy} = 3'h0;
        rx_in = '{1'h0, 1'h1, 1'h1};
        forever begin
            @(posedge ref_clk);
            if (go === 1'h1) begin
                busy <= 1'h1;
                if (tx) begin
                    step(0);
                    step(1);
                    step(2);
                    step(4);
                end else begin
                    step(3);
                end
                step(5);
                // Fast frames send bits back to back; slow ones leave gaps
                for (int k = 0; k < nbits; k++) begin
                    rx_in <= '{1'h1, bits[k], k == conf_at};
                    {crc, par} <= (k == 2) ? err : 2'h0;
                    @(posedge ref_clk);
                    if (slow) begin
                        rx_in <= '{1'h0, !bits[k], k != conf_at};
                        {crc, par} <= 2'h0;
                        repeat (2) @(posedge ref_clk);
                    end
                end
                // A released line shows the inverse, never a held copy
                rx_in <= '{1'h0, !bits[nbits - 1], 1'h1};
                {crc, par} <= 2'h0;
                step(6);
                repeat (4) @(posedge ref_clk);
                busy <= 1'h0;
            end
        end
    end
endmodule

/* test/rbc_top_sva.sv */
// Port level checks of the receive bit handling block
`timescale 1ns/1ns
module rbc_top_sva (
    // Clock and reset
    input logic                 ref_clk,
    input logic                 reset,
    // Register bus
    input logic [7:0]           avs_address,
    input logic                 avs_read,
    input logic                 avs_write,
    input logic [31:0]          avs_writedata,
    input logic [3:0]           avs_byteenable,
    input logic [31:0]          avs_readdata,
    input logic                 avs_waitrequest,
    // Framing events
    input logic                 ev_tx_request,
    input logic                 ev_tx_begin,
    input logic                 ev_rx_guard_done,
    input logic                 ev_rx_sof,
    input logic                 ev_rx_end,
    input logic                 ev_auth_done,
    // Data and status
    input rbc_pkg::rbc_rx_bit_t rx_in,
    input rbc_pkg::rbc_byte_t   byte_out,
    input logic                 cipher_active,
    input logic [2:0]           transceive_state
);
    import rbc_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic rd_ok;
    logic stat_wr;
    assign rd_ok = avs_read && !avs_waitrequest;
    assign stat_wr = avs_write && !avs_waitrequest && avs_address[7:2] == 6'h0b && avs_byteenable[0];
    sequence rx_done_s;
        transceive_state == 3'h7 && ev_rx_end;
    endsequence
    // Auth pulse wins over a host clear in the same cycle
    sequence host_clear_s;
        stat_wr && !avs_writedata[5] && !ev_auth_done;
    endsequence
    property step_p(logic [2:0] from, logic ev, logic [2:0] to);
        transceive_state == from && ev |=> transceive_state == to;
    endproperty
    code_unused_a: assert property (transceive_state != 3'h4)
        else $error("unused state code shown");
    tx_request_a: assert property (step_p(3'h0, ev_tx_request, 3'h1))
        else $error("idle did not go to transmit wait");
    tx_begin_a: assert property (step_p(3'h1, ev_tx_begin, 3'h3))
        else $error("transmit wait did not go to transmitting");
    guard_done_a: assert property (step_p(3'h5, ev_rx_guard_done, 3'h6))
        else $error("receive wait did not go to wait for data");
    sof_seen_a: assert property (step_p(3'h6, ev_rx_sof, 3'h7))
        else $error("start of frame did not enter receiving");
    rx_done_a: assert property (rx_done_s |=> transceive_state == 3'h0)
        else $error("end of frame did not return to idle");
    cipher_hold_a: assert property (!cipher_active && !ev_auth_done |=> !cipher_active)
        else $error("cipher set without authentication");
    cipher_set_a: assert property (ev_auth_done |=> cipher_active)
        else $error("authentication did not set cipher");
    cipher_clear_a: assert property (host_clear_s |=> !cipher_active)
        else $error("host clear left cipher on");
    status_read_a: assert property (rd_ok && avs_address[7:2] == 6'h0b |->
        avs_readdata[7:0] == {2'h0, $past(cipher_active), 2'h0, $past(transceive_state)})
        else $error("status readback wrong");
    coll_range_a: assert property (rd_ok && avs_address[7:2] == 6'h0d && avs_readdata[7] |-> !avs_readdata[6])
        else $error("valid collision position above 3f");
    coll_clear_a: assert property (rd_ok && avs_address[7:2] == 6'h0d && !avs_readdata[7] |->
        avs_readdata[6:0] == 7'h0)
        else $error("invalid collision position not zero");
    byte_cause_a: assert property (byte_out.valid |-> $past(rx_in.valid) || $past(ev_rx_end))
        else $error("byte emitted without a bit or frame end");
endmodule
bind rbc_top rbc_top_sva u_sva (.ref_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ev_tx_request, .ev_tx_begin, .ev_rx_guard_done,
    .ev_rx_sof, .ev_rx_end, .ev_auth_done, .rx_in, .byte_out, .cipher_active, .transceive_state);

/* test/rbc_top_tb.sv */
// Self-checking bench of the receive bit handling block
`timescale 1ns/1ns
module rbc_top_tb;
    import rbc_pkg::*;
    logic        ref_clk = 1'h0;
    logic        reset = 1'h1;
    logic [7:0]  avs_address = 8'h0;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ev_auth_done = 1'h0;
    logic        go = 1'h0, tx = 1'h0, slow = 1'h0;
    logic [6:0]  nbits = 7'h0, conf_at = 7'h0;
    logic [63:0] bits = 64'h0;
    logic [1:0]  err = 2'h0;
    logic [6:0]  ev;
    logic        par, crc, busy, cipher_active, irq;
    logic [2:0]  transceive_state;
    rbc_rx_bit_t rx_in;
    rbc_byte_t   byte_out;
    logic [31:0] lfsr_q = 32'h6af2, q;
    logic [7:0]  seen = 8'h0;
    logic [8:0]  got[$];
    int          num_errors = 0, compares = 0;
    rbc_top dut (.ref_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .ev_tx_request(ev[0]), .ev_tx_begin(ev[1]), .ev_tx_end(ev[2]),
        .ev_rx_request(ev[3]), .ev_rx_guard_done(ev[4]), .ev_rx_sof(ev[5]), .ev_rx_end(ev[6]),
        .ev_parity_err(par), .ev_crc_err(crc), .ev_auth_done, .rx_in, .byte_out, .cipher_active,
        .transceive_state, .irq);
    rbc_card_model card (.ref_clk, .go, .tx, .slow, .nbits, .bits, .conf_at, .err, .ev, .par, .crc, .rx_in, .busy);
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (byte_out.valid === 1'h1) got.push_back({byte_out.last, byte_out.data});
        seen[transceive_state] <= 1'h1;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic summarize;
        $display("Comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 20);
        if (n == 20) begin
            num_errors++;
            summarize();
        end
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic frame(input logic t, s, input logic [2:0] slot, input logic keep, integ,
                         input logic [6:0] n, ca, input logic [1:0] e);
        int pos, k, cp;
        logic [63:0] r;
        logic [7:0] cur, msk;
        logic [8:0] eq[$], mq[$];
        logic hit;
        lfsr_q = lfsr(lfsr_q);
        r[63:32] = lfsr_q;
        lfsr_q = lfsr(lfsr_q);
        r[31:0] = lfsr_q;
        bus(1'h1, 8'h30, {keep, slot, integ, 3'h0});
        {tx, slow, nbits, conf_at, err, bits, go} <= {t, s, n, ca, e, r, 1'h1};
        @(posedge ref_clk);
        go <= 1'h0;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (busy !== 1'h0 && k < 3000);
        if (k == 3000) begin
            num_errors++;
            summarize();
        end
        {pos, cur, msk, hit} = {slot, 17'h0};
        for (k = 0; k < n; k++) begin
            cur[pos] = r[k] & (keep | !hit);
            msk[pos] = 1'h1;
            if (k == ca) hit = 1'h1;
            pos++;
            if (pos == 8) begin
                eq.push_back({1'h0, cur});
                mq.push_back({1'h1, msk});
                {pos, cur, msk} = 48'h0;
            end
        end
        if (pos != 0) begin
            eq.push_back({1'h1, cur});
            mq.push_back({1'h1, msk});
        end
        chk("byte count", eq.size(), got.size());
        foreach (eq[i]) chk("byte", eq[i], got[i] & mq[i]);
        got.delete();
        cp = slot + ca;
        bus(1'h0, 8'h34, 8'h0);
        chk("collision", (ca < n && cp < 64) ? {1'h1, cp[6:0]} : 8'h0, q);
        bus(1'h0, 8'h28, 8'h0);
        chk("error", {29'h0, ca < n, 1'h0, e != 0 || (integ && ca < n)}, q);
        bus(1'h0, 8'h30, 8'h0);
        chk("bit control", {keep, slot, integ, slot != 0 ? pos[2:0] : 3'h0}, q);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'h0;
        @(posedge ref_clk);
        bus(1'h0, 8'h30, 8'h0);
        chk("bit control reset", 0, q);
        avs_byteenable <= 4'h0;
        bus(1'h1, 8'h30, 8'h70);
        avs_byteenable <= 4'hf;
        bus(1'h1, 8'h34, 8'hff);
        bus(1'h1, 8'h40, 8'hff);
        bus(1'h0, 8'h40, 8'h0);
        chk("unmapped", 0, q);
        bus(1'h0, 8'h34, 8'h0);
        chk("collision read only", 0, q);
        bus(1'h0, 8'h30, 8'h0);
        chk("byte enable", 0, q);
        bus(1'h1, 8'h2c, 8'hff);
        bus(1'h0, 8'h2c, 8'h0);
        chk("status", 0, q);
        ev_auth_done <= 1'h1;
        @(posedge ref_clk);
        ev_auth_done <= 1'h0;
        @(posedge ref_clk);
        bus(1'h1, 8'h2c, 8'h20);
        bus(1'h0, 8'h2c, 8'h0);
        chk("status", 32'h20, q);
        chk("cipher", 1, cipher_active);
        bus(1'h1, 8'h2c, 8'h00);
        bus(1'h0, 8'h2c, 8'h0);
        chk("status", 0, q);
        frame(1'h0, 1'h0, 3'h4, 1'h0, 1'h0, 7'd13, 7'd3, 2'h0);
        frame(1'h1, 1'h1, 3'h0, 1'h0, 1'h0, 7'd16, 7'd127, 2'h0);
        frame(1'h1, 1'h0, 3'h3, 1'h0, 1'h1, 7'd13, 7'd8, 2'h0);
        frame(1'h0, 1'h1, 3'h7, 1'h1, 1'h0, 7'd10, 7'd1, 2'h1);
        frame(1'h1, 1'h0, 3'h1, 1'h0, 1'h0, 7'd64, 7'd63, 2'h0);
        frame(1'h0, 1'h0, 3'h0, 1'h1, 1'h0, 7'd64, 7'd63, 2'h2);
        chk("state codes", 8'heb, seen);
        bus(1'h0, 8'h80, 8'h0);
        chk("event status", 7, q);
        chk("masked irq", 0, irq);
        bus(1'h1, 8'h84, 8'h04);
        chk("irq", 1, irq);
        bus(1'h1, 8'h80, 8'h07);
        chk("cleared irq", 0, irq);
        bus(1'h0, 8'h80, 8'h0);
        chk("event status", 0, q);
        summarize();
    end
endmodule
